// ---- sim/idle_powerdown_mode_control_test.sv ----
`timescale 1ns/1ps
module idle_powerdown_mode_control_test;
	import ipm_pkg::*;
	logic       ref_clk = 0, rst_req = 0, ew_req = 0, irq = 0, ext_mem = 0;
	// run strobes differ so that the forced idle and power-down levels show
	logic       ale_run = 0, program_store_strobe_run = 1;
	// two synchroniser flops plus the in_idle output register
	localparam logic [7:0] WAKE_EDGES = 8'h03;
	ipm_wr_s    wr = '0;
	wire logic  rst, ew;
	ipm_ctl_s   ctl;
	logic [7:0] pcr, hap;
	logic       idl, pd, oe_n, als, pss, po0, po1;
	int         errors = 0, n_tests = 0;
	// free running system clock
	initial forever #10 ref_clk = ~ref_clk;
	ipm_partner u_ptn (.rst_req(rst_req), .ref_clk(ref_clk), .ew_req(ew_req), .rst(rst),
		.watchdog_enable_pin(ew));
	ipm_power_ctrl u_dut (.ref_clk(ref_clk), .rst(rst), .power_control_reg_wr(wr), .watchdog_enable_pin(ew),
		.irq_pending(irq), .ext_mem(ext_mem), .port2_reg(8'ha5), .addr_hi(8'h3c),
		.ale_run(ale_run), .program_store_strobe_run(program_store_strobe_run), .ctl(ctl), .power_control_reg(pcr),
		.in_idle(idl),
		.in_pd(pd), .high_address_port(hap), .port0_oe_n(oe_n), .address_latch_strobe(als),
		.program_store_strobe(pss), .pulse_output_0(po0), .pulse_output_1(po1));
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// sample one step after the edge so updates have landed
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic wr_b(input logic bop, input logic [7:0] d);
		@(posedge ref_clk);
		wr <= '{1'b1, bop, d};
		@(posedge ref_clk);
		wr <= '0;
		#1;
	endtask
	// pin levels change on an edge; then the partner and two flops catch up
	task automatic pins(input logic ew, input logic xm);
		@(posedge ref_clk);
		ew_req  <= ew;
		ext_mem <= xm;
		cyc(4);
	endtask
	// raise the interrupt on an edge and count edges until idle ends
	task automatic wake(output int n);
		@(posedge ref_clk);
		irq <= 1'b1;
		n = 0;
		while (idl === 1'b1 && n < 8) begin
			cyc(1);
			n++;
		end
		@(posedge ref_clk);
		irq <= 1'b0;
		#1;
	endtask
	// a reset pulse; the partner stretches it before release
	task automatic hw_reset;
		@(posedge ref_clk);
		rst_req <= 1'b1;
		@(posedge ref_clk);
		rst_req <= 1'b0;
		cyc(20);
	endtask
	task automatic t_idle;
		int n;
		pins(1'b1, 1'b1);
		chk("strobes_run", {als, pss}, 2'h1);
		wr_b(1'b0, 8'h01);
		chk("in_idle", idl, 1'h1);
		chk("pcr_idle", pcr, 8'h01);
		chk("ctl_idle", ctl, 6'h3F);
		chk("pulses_idle", {po1, po0}, 2'h3);
		chk("strobes_idle", {als, pss}, 2'h3);
		chk("p0_idle", oe_n, 1'h1);
		chk("p2_idle", hap, 8'h3C);
		wr_b(1'b0, 8'h02);
		chk("idle_wr_pd", pd, 1'h0);
		chk("idle_wr_pcr", pcr, 8'h01);
		wake(n);
		chk("wake_edges", n[7:0], WAKE_EDGES);
		chk("wake", idl, 1'h0);
		chk("ctl_run", ctl, 6'h03);
		chk("pcr_wake", pcr, 8'h00);
		$display("t_idle done");
	endtask
	task automatic t_refuse;
		int n;
		wr_b(1'b1, 8'h01);
		chk("bit_op_idle", idl, 1'h0);
		wr_b(1'b1, 8'h02);
		chk("bit_op_pd", pd, 1'h0);
		chk("bit_op_pcr", pcr, 8'h00);
		pins(1'b0, 1'b1);
		wr_b(1'b0, 8'h02);
		chk("pd_no_ew", pd, 1'h0);
		chk("pcr_no_ew", pcr, 8'h00);
		wr_b(1'b0, 8'h03);
		chk("idle_no_ew", idl, 1'h1);
		chk("pd_no_ew_both", pd, 1'h0);
		chk("pcr_no_ew_both", pcr, 8'h01);
		wake(n);
		chk("wake_no_ew", idl, 1'h0);
		$display("t_refuse done");
	endtask
	task automatic t_pd;
		pins(1'b1, 1'b1);
		wr_b(1'b0, 8'h02);
		chk("in_pd", pd, 1'h1);
		chk("pcr_pd", pcr, 8'h02);
		chk("ctl_pd", ctl, 6'h3C);
		chk("strobes_pd", {als, pss}, 2'h0);
		chk("p0_pd", oe_n, 1'h1);
		chk("p2_pd", hap, 8'hA5);
		chk("pulses_pd", {po1, po0}, 2'h3);
		@(posedge ref_clk);
		irq <= 1'b1;
		cyc(6);
		chk("irq_no_exit", pd, 1'h1);
		chk("irq_no_idle", idl, 1'h0);
		wr_b(1'b0, 8'h01);
		chk("frozen_pcr", pcr, 8'h02);
		chk("frozen_ctl", ctl, 6'h3C);
		@(posedge ref_clk);
		irq <= 1'b0;
		hw_reset;
		chk("rst_pcr", pcr, 8'h00);
		chk("rst_pd", pd, 1'h0);
		chk("rst_ctl", ctl, 6'h03);
		chk("rst_strobes", {als, pss}, 2'h1);
		chk("rst_p2", hap, 8'h3C);
		$display("t_pd done");
	endtask
	task automatic t_idle_int;
		pins(1'b1, 1'b0);
		chk("p2_run_int", hap, 8'hA5);
		wr_b(1'b0, 8'h01);
		chk("in_idle_int", idl, 1'h1);
		chk("p0_idle_int", oe_n, 1'h0);
		chk("p2_idle_int", hap, 8'hA5);
		hw_reset;
		chk("rst_idle", idl, 1'h0);
		chk("rst_idle_ctl", ctl, 6'h03);
		$display("t_idle_int done");
	endtask
	task automatic test_done;
		$display("checks %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// main sequence after the partner's startup reset
	initial begin
		cyc(18);
		t_idle;
		t_refuse;
		t_pd;
		t_idle_int;
		test_done;
	end
	// tests take about 120 cycles; far beyond means a hang
	initial begin
		#20000;
		errors++;
		test_done;
	end
endmodule

// ---- sim/ipm_partner.sv ----
`timescale 1ns/1ps
// reset source and watchdog enable pin outside the device
module ipm_partner (
	input  wire logic rst_req,
	input  wire logic ref_clk,
	input  wire logic ew_req,
	output logic      rst,
	output logic      watchdog_enable_pin
);
	int cnt = 16;
	initial watchdog_enable_pin = 1'b0;
	// reset stretched so a stopped oscillator can settle first
	always @(posedge ref_clk) begin
		if (rst_req) cnt <= 16;
		else if (cnt > 0) cnt <= cnt - 1;
	end
	assign rst = (cnt > 0);
	// pin level follows the request on the clock
	always @(posedge ref_clk) watchdog_enable_pin <= ew_req;
endmodule

// ---- verilog/ipm_pkg.sv ----
package ipm_pkg;
	// power control register layout
	localparam logic [7:0] POWER_CONTROL_REG_RESET     = 8'h00;
	localparam int         IDLE_BIT_POS   = 0;
	localparam int         PD_BIT_POS     = 1;
	localparam logic [7:0] PORT_RESET     = 8'hFF;
	localparam logic [7:0] PULSE_HIGH     = 8'hFF;

	typedef enum logic [2:0] {
		IPM_RUN  = 3'b001,
		IPM_IDLE = 3'b010,
		IPM_PD   = 3'b100
	} ipm_mode_e;

	// software write to the power control register (byte write or bit operation)
	typedef struct packed {
		logic       wr;
		logic       bit_op;
		logic [7:0] data;
	} ipm_wr_s;

	// unit control outputs
	typedef struct packed {
		logic cpu_halt;
		logic t2_reset;
		logic pwm_reset;
		logic adc_abort;
		logic periph_run;
		logic osc_run;
	} ipm_ctl_s;
endpackage

// ---- verilog/ipm_power_ctrl.sv ----
`timescale 1ns/1ps
// Overview of operation
// - entering idle halts the cpu and stops and resets the capture timer.
// - entering idle resets both pulse outputs and drives them high.
// - entering idle aborts any conversion in progress.
// - in idle the timers, watchdog, serial ports and external interrupts keep running.
// - setting the power-down bit enters power-down and stops the oscillator.
// - the write setting the power-down bit is the last instruction run before power-down.
// - the power-down bit can only be set while the watchdog enable pin is high.
// - in power-down everything is frozen and ram and registers keep their values.
// - in power-down each port pin drives its port register value, but port 0 floats with external memory.
// - only a hardware reset leaves power-down; interrupts do not.
// - the reset ending power-down restores register defaults but leaves ram alone.
// - in power-down from external memory the high address port shows its register.
// - a port latch holding one is driven high by the strong pull-up in power-down.
// - strobes high in idle, low in power-down; port 0 floats with external memory and port 2 as tabled.
// - the power control register takes byte writes only, never bit operations.
module ipm_power_ctrl
	import ipm_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire ipm_wr_s    power_control_reg_wr,
	input  wire logic       watchdog_enable_pin,
	input  wire logic       irq_pending,
	input  wire logic       ext_mem,
	input  wire logic [7:0] port2_reg,
	input  wire logic [7:0] addr_hi,
	input  wire logic       ale_run,
	input  wire logic       program_store_strobe_run,
	output ipm_ctl_s        ctl,
	output logic [7:0]      power_control_reg,
	output logic            in_idle,
	output logic            in_pd,
	output logic [7:0]      high_address_port,
	output logic            port0_oe_n,
	output logic            address_latch_strobe,
	output logic            program_store_strobe,
	output logic            pulse_output_0,
	output logic            pulse_output_1
);

	ipm_mode_e  mode;
	ipm_mode_e  next_mode;
	logic       ew_meta;
	logic       ew_sync;
	logic       irq_meta;
	logic       irq_sync;
	logic       byte_wr;

	// the core, capture timer, pulse unit and converter all stop outside run
	function automatic logic ipm_halts_core(input ipm_mode_e m);
		return (m != IPM_RUN);
	endfunction

	// the watchdog pin and the interrupt pass two flops before use
	// no reset here: they only carry levels, flushed within two edges of reset
	always_ff @(posedge ref_clk) begin
		ew_meta  <= watchdog_enable_pin;
		ew_sync  <= ew_meta;
		irq_meta <= irq_pending;
		irq_sync <= irq_meta;
	end

	// bit operations are ignored entirely, frozen while powered down
	// idle writes pass here; the register loads only in run, so idle keeps its image as well
	assign byte_wr = power_control_reg_wr.wr && !power_control_reg_wr.bit_op && (mode != IPM_PD);

	// mode sequencing; reset is the only exit from power-down
	always_comb begin
		next_mode = mode;
		case (mode)
			IPM_RUN: begin
				if (byte_wr && power_control_reg_wr.data[PD_BIT_POS] && ew_sync)
					next_mode = IPM_PD;
				else if (byte_wr && power_control_reg_wr.data[IDLE_BIT_POS])
					next_mode = IPM_IDLE;
			end
			IPM_IDLE: begin
				if (irq_sync)
					next_mode = IPM_RUN;
			end
			IPM_PD: next_mode = IPM_PD;
			default: next_mode = IPM_RUN;
		endcase
	end

	// mode register; reset is the one path that clears every mode
	always_ff @(posedge ref_clk) begin
		if (rst)
			mode <= IPM_RUN;
		else
			mode <= next_mode;
	end

	// register image; pd bit cannot be set with watchdog pin low
	always_ff @(posedge ref_clk) begin
		if (rst)
			power_control_reg <= POWER_CONTROL_REG_RESET;
		else if (byte_wr && mode == IPM_RUN) begin
			power_control_reg <= power_control_reg_wr.data;
			if (!ew_sync)
				power_control_reg[PD_BIT_POS] <= 1'b0;
		end else if (mode == IPM_IDLE && next_mode == IPM_RUN)
			power_control_reg[IDLE_BIT_POS] <= 1'b0;
	end

	// unit controls; ram has no reset path here so it is retained
	always_ff @(posedge ref_clk) begin
		if (rst)
			ctl <= '{default: 1'b0, periph_run: 1'b1, osc_run: 1'b1};
		else begin
			ctl.cpu_halt   <= ipm_halts_core(next_mode);
			ctl.t2_reset   <= ipm_halts_core(next_mode);
			ctl.pwm_reset  <= ipm_halts_core(next_mode);
			ctl.adc_abort  <= ipm_halts_core(next_mode);
			ctl.periph_run <= (next_mode != IPM_PD);
			ctl.osc_run    <= (next_mode != IPM_PD);
		end
	end

	// pin states per mode
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			in_idle              <= 1'b0;
			in_pd                <= 1'b0;
			high_address_port    <= PORT_RESET;
			port0_oe_n           <= 1'b1;
			address_latch_strobe <= 1'b1;
			program_store_strobe <= 1'b1;
			pulse_output_0       <= 1'b1;
			pulse_output_1       <= 1'b1;
		end else begin
			in_idle        <= (next_mode == IPM_IDLE);
			in_pd          <= (next_mode == IPM_PD);
			pulse_output_0 <= 1'b1;
			pulse_output_1 <= 1'b1;
			case (next_mode)
				IPM_IDLE: begin
					address_latch_strobe <= 1'b1;
					program_store_strobe <= 1'b1;
					port0_oe_n           <= ext_mem;
					high_address_port    <= ext_mem ? addr_hi : port2_reg;
				end
				IPM_PD: begin
					address_latch_strobe <= 1'b0;
					program_store_strobe <= 1'b0;
					port0_oe_n           <= ext_mem;
					// latch ones go out on the strong pull-up
					high_address_port    <= port2_reg;
				end
				default: begin
					address_latch_strobe <= ale_run;
					program_store_strobe <= program_store_strobe_run;
					port0_oe_n           <= 1'b0;
					high_address_port    <= ext_mem ? addr_hi : port2_reg;
				end
			endcase
		end
	end

	// checks
	chk_pd_needs_ew: assert property (@(posedge ref_clk) disable iff (rst)
		($rose(in_pd)) |-> $past(ew_sync, 1))
		else $error("power-down entered with watchdog pin low");
	chk_pd_sticky: assert property (@(posedge ref_clk) disable iff (rst)
		in_pd |=> in_pd)
		else $error("power-down left without reset");
	chk_osc_stop_pd: assert property (@(posedge ref_clk) disable iff (rst)
		in_pd |-> !ctl.osc_run && ctl.cpu_halt)
		else $error("oscillator running in power-down");
	chk_idle_units: assert property (@(posedge ref_clk) disable iff (rst)
		in_idle |-> ctl.t2_reset && ctl.cpu_halt && ctl.adc_abort && ctl.pwm_reset)
		else $error("idle without unit reset");
	chk_idle_periph: assert property (@(posedge ref_clk) disable iff (rst)
		in_idle |-> ctl.periph_run && ctl.osc_run)
		else $error("peripherals stopped in idle");
	chk_pulse_high: assert property (@(posedge ref_clk) disable iff (rst)
		(in_idle || in_pd) |-> pulse_output_0 && pulse_output_1)
		else $error("pulse output low in reduced mode");
	chk_strobe_pd: assert property (@(posedge ref_clk) disable iff (rst)
		in_pd |-> !address_latch_strobe && !program_store_strobe)
		else $error("strobes not low in power-down");
	chk_p2_pd: assert property (@(posedge ref_clk) disable iff (rst)
		in_pd |-> high_address_port == $past(port2_reg, 1))
		else $error("port 2 not showing register in power-down");
	chk_bit_op: assert property (@(posedge ref_clk) disable iff (rst)
		(power_control_reg_wr.wr && power_control_reg_wr.bit_op && !in_pd && !in_idle) |=> $stable(power_control_reg))
		else $error("bit operation changed power control");
	chk_idle_wake: assert property (@(posedge ref_clk) disable iff (rst)
		(in_idle && irq_sync) |=> ##[0:1] !in_idle)
		else $error("idle not left on interrupt");
	chk_pd_frozen: assert property (@(posedge ref_clk) disable iff (rst)
		in_pd |=> $stable(power_control_reg) && $stable(ctl))
		else $error("state changed in power-down");
	chk_pd_bit_ew: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(power_control_reg[PD_BIT_POS]) |-> $past(ew_sync, 1))
		else $error("power-down bit set with watchdog pin low");

	// pin levels in the reduced modes
	chk_strobe_idle: assert property (@(posedge ref_clk) disable iff (rst)
		in_idle |-> address_latch_strobe && program_store_strobe)
		else $error("strobes not high in idle");
	chk_p0_float: assert property (@(posedge ref_clk) disable iff (rst)
		(in_idle || in_pd) |-> port0_oe_n == $past(ext_mem, 1))
		else $error("port 0 not floating with external memory");
	chk_p2_idle: assert property (@(posedge ref_clk) disable iff (rst)
		in_idle |-> high_address_port ==
			($past(ext_mem, 1) ? $past(addr_hi, 1) : $past(port2_reg, 1)))
		else $error("port 2 wrong in idle");

	// main scenarios, including a refused power-down request
	cov_idle: cover property (@(posedge ref_clk) disable iff (rst) $rose(in_idle));
	cov_pd: cover property (@(posedge ref_clk) disable iff (rst) $rose(in_pd));
	cov_wake: cover property (@(posedge ref_clk) disable iff (rst) $fell(in_idle));
	cov_pd_ext: cover property (@(posedge ref_clk) disable iff (rst) in_pd && ext_mem);
	cov_pd_refused: cover property (@(posedge ref_clk) disable iff (rst)
		power_control_reg_wr.wr && !power_control_reg_wr.bit_op && power_control_reg_wr.data[PD_BIT_POS] && !ew_sync && !in_pd);

endmodule
